// ### lbm_pkg.sv
// Purpose: shared constants and types for the local bus master
// Assumes: one clk_sys domain carrying the double-rate bus clock
// Notes:   bus state codes, size codes, pin carriers
package lbm_pkg;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_LSB  = 2;
  localparam int unsigned SIZE_W    = 2;
  localparam int unsigned WADDR_W   = DATA_W - ADDR_LSB;

  // size code is burst length in words minus one
  localparam logic [SIZE_W-1:0] SIZE_ONE  = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_FOUR = 2'h3;
  localparam logic [SIZE_W-1:0] WORD_STEP = 2'h1;

  localparam logic PH_RST   = 1'b0;
  localparam logic PH_LAST  = 1'b1;
  localparam logic ACT_N    = 1'b0;
  localparam logic IDLE_N   = 1'b1;
  localparam logic OE_ON    = 1'b0;
  localparam logic OE_OFF   = 1'b1;
  localparam logic DIR_RX   = 1'b0;
  localparam logic DIR_TX   = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOCKW = 3'h1,
    ST_ADDR  = 3'h2,
    ST_DATA  = 3'h3,
    ST_HOLD  = 3'h4
  } lbm_state_t;

  typedef struct packed {
    logic               valid;
    logic [WADDR_W-1:0] addr;
    logic [SIZE_W-1:0]  size;
    logic               wr;
    logic               atomic_read_then_write;
    logic               inta;
  } lbm_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } lbm_rdata_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              ready_n;
    logic              lock_n;
    logic              hold;
  } lbm_pins_t;

  localparam lbm_pins_t SYNC_RST = '{data: '0, ready_n: 1'b1,
                                     lock_n: 1'b1, hold: 1'b0};
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0;
endpackage

// ### lbm_master.sv
// Purpose: multiplexed local address/data bus master
// Assumes: clk_sys is the double-rate bus clock; core holds a request
//          until req_ready, and wdata until wdata_take
// Notes:   pin inputs pass two flip-flops, so ready is seen late
`timescale 1ns/1ps
module lbm_master
  import lbm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire lbm_req_t          core_req,
  output logic                   req_ready,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   wdata_take,
  output lbm_rdata_t             rdata,
  output logic                   xfer_done,
  input  wire logic              hold_req_in,
  output logic                   hold_grant,
  input  wire logic [DATA_W-1:0] muxed_addr_data_in,
  output logic [DATA_W-1:0]      muxed_addr_data_out,
  output logic                   muxed_addr_data_oe_b,
  output logic                   addr_latch_strobe_n,
  output logic                   addr_latch_strobe_oe_b,
  output logic                   addr_data_strobe_n,
  output logic                   write_not_read,
  output logic                   xcvr_direction,
  output logic                   xcvr_enable_n,
  output logic                   xcvr_enable_oe_b,
  input  wire logic              ready_n_in,
  input  wire logic              bus_lock_n_in,
  output logic                   bus_lock_n_out,
  output logic                   bus_lock_oe_b
);

  lbm_pins_t          sync1_q, sync2_q;
  lbm_state_t         st_q, st_d;
  logic               ph_q, ph_d;
  logic [SIZE_W-1:0]  left_q, left_d, size_q, size_d;
  logic [WADDR_W-1:0] addr_q, addr_d;
  logic               nxt_q, nxt_d, wr_q, wr_d, rmw_q, rmw_d;
  logic               own_q, own_d, dir_q, dir_d;
  logic               ale_q, ale_d, ale_oe_q, ale_oe_d, strb_q, strb_d;
  logic               xen_q, xen_d, mad_oe_q, mad_oe_d, hold_q, hold_d;
  logic               done_q, done_d;
  logic [DATA_W-1:0]  mad_q, mad_d;
  lbm_rdata_t         rd_q, rd_d;
  logic               adv, rdy, last, word_ok, rmw_turn, lock_free;
  logic               can_start, start;

  // open-drain pins only ever pull low; the enable does the work
  assign xcvr_enable_n          = ACT_N;
  assign bus_lock_n_out         = ACT_N;
  assign muxed_addr_data_out    = mad_q;
  assign muxed_addr_data_oe_b   = mad_oe_q;
  assign addr_latch_strobe_n    = ale_q;
  assign addr_latch_strobe_oe_b = ale_oe_q;
  assign addr_data_strobe_n     = strb_q;
  assign write_not_read         = wr_q;
  assign xcvr_direction         = dir_q;
  assign xcvr_enable_oe_b       = xen_q;
  assign bus_lock_oe_b          = !own_q;
  assign hold_grant             = hold_q;
  assign rdata                  = rd_q;
  assign xfer_done              = done_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else if (clk_en) begin
      sync1_q <= '{data: muxed_addr_data_in, ready_n: ready_n_in,
                   lock_n: bus_lock_n_in, hold: hold_req_in};
      sync2_q <= sync1_q;
    end
  end

  // one processor cycle is two clk_sys edges; ph_q marks the second
  assign adv       = clk_en && (ph_q == PH_LAST);
  assign rdy       = (sync2_q.ready_n == ACT_N);
  assign last      = (left_q == SIZE_ONE);
  assign word_ok   = (st_q == ST_DATA) && rdy;
  assign rmw_turn  = rmw_q && !wr_q;
  // our own pull-down is ignored when judging whether lock is free
  assign lock_free = (sync2_q.lock_n == IDLE_N) || own_q;
  assign can_start = ((st_q == ST_IDLE) && !sync2_q.hold) ||
                     (word_ok && last && !rmw_turn);
  assign req_ready = adv && can_start;
  assign start     = req_ready && core_req.valid;
  assign wdata_take = adv && word_ok && wr_q;

  always_comb begin
    st_d   = st_q;
    ph_d   = ~ph_q;
    left_d = left_q;
    size_d = size_q;
    addr_d = addr_q;
    nxt_d  = nxt_q;
    wr_d   = wr_q;
    rmw_d  = rmw_q;
    own_d  = own_q;
    done_d = 1'b0;
    rd_d   = '{valid: 1'b0, data: rd_q.data};
    if (adv) begin
      case (st_q)
        ST_IDLE: begin
          if (sync2_q.hold) begin
            st_d = ST_HOLD;
          end
        end
        ST_LOCKW: begin
          if (lock_free) begin
            st_d  = ST_ADDR;
            own_d = 1'b1;
          end
        end
        ST_ADDR: begin
          st_d  = ST_DATA;
          nxt_d = 1'b0;
        end
        ST_DATA: begin
          if (!rdy) begin
            nxt_d = 1'b0;
          end else begin
            rd_d = '{valid: !wr_q, data: sync2_q.data};
            if (!last) begin
              left_d = left_q - WORD_STEP;
              nxt_d  = 1'b1;
            end else if (rmw_turn) begin
              // write half of the atomic pair reuses address and size
              st_d   = ST_ADDR;
              wr_d   = 1'b1;
              left_d = size_q;
              own_d  = 1'b0;
            end else begin
              st_d   = ST_IDLE;
              own_d  = 1'b0;
              done_d = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (!sync2_q.hold) begin
            st_d = ST_IDLE;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    if (start) begin
      addr_d = core_req.addr;
      size_d = core_req.size;
      left_d = core_req.size;
      wr_d   = core_req.wr && !core_req.atomic_read_then_write && !core_req.inta;
      rmw_d  = core_req.atomic_read_then_write;
      if (core_req.atomic_read_then_write || core_req.inta) begin
        st_d = lock_free ? ST_ADDR : ST_LOCKW;
        own_d = lock_free;
      end else begin
        st_d = ST_ADDR;
      end
    end
  end

  // pin drive follows the next state so pins line up with st_q
  always_comb begin
    ale_d    = (st_d == ST_ADDR) ? ACT_N : IDLE_N;
    ale_oe_d = (st_d == ST_HOLD) ? OE_OFF : OE_ON;
    strb_d   = ((st_d == ST_ADDR) || ((st_d == ST_DATA) && nxt_d)) ?
               ACT_N : IDLE_N;
    xen_d    = (st_d == ST_DATA) ? OE_ON : OE_OFF;
    mad_oe_d = ((st_d == ST_ADDR) || ((st_d == ST_DATA) && wr_d)) ?
               OE_ON : OE_OFF;
    mad_d    = (st_d == ST_ADDR) ? {addr_d, size_d} : wdata;
    hold_d   = (st_d == ST_HOLD);
    // direction only moves while the transceivers are already off,
    // which costs half a processor cycle at the start of each address
    dir_d    = dir_q;
    if ((st_q == ST_ADDR) && (xen_q == OE_OFF)) begin
      dir_d = wr_q ? DIR_TX : DIR_RX;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= ST_IDLE;
      ph_q     <= PH_RST;
      left_q   <= SIZE_ONE;
      size_q   <= SIZE_ONE;
      addr_q   <= '0;
      nxt_q    <= 1'b0;
      wr_q     <= 1'b0;
      rmw_q    <= 1'b0;
      own_q    <= 1'b0;
      done_q   <= 1'b0;
      rd_q     <= '{valid: 1'b0, data: ZERO_WORD};
      ale_q    <= IDLE_N;
      ale_oe_q <= OE_ON;
      strb_q   <= IDLE_N;
      xen_q    <= OE_OFF;
      mad_oe_q <= OE_OFF;
      mad_q    <= ZERO_WORD;
      hold_q   <= 1'b0;
      dir_q    <= DIR_RX;
    end else if (clk_en) begin
      st_q     <= st_d;
      ph_q     <= ph_d;
      left_q   <= left_d;
      size_q   <= size_d;
      addr_q   <= addr_d;
      nxt_q    <= nxt_d;
      wr_q     <= wr_d;
      rmw_q    <= rmw_d;
      own_q    <= own_d;
      done_q   <= done_d;
      rd_q     <= rd_d;
      ale_q    <= ale_d;
      ale_oe_q <= ale_oe_d;
      strb_q   <= strb_d;
      xen_q    <= xen_d;
      mad_oe_q <= mad_oe_d;
      mad_q    <= mad_d;
      hold_q   <= hold_d;
      dir_q    <= dir_d;
    end
  end

  logic [SIZE_W:0] seen_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= '0;
    end else if (adv && (st_q == ST_ADDR)) begin
      seen_q <= '0;
    end else if (adv && word_ok) begin
      seen_q <= seen_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_state_half_rate: assert property (
    $changed(st_q) |-> $past(ph_q) && $past(clk_en))
    else $error("bus state moved on a first-half edge");
  a_addr_on_bus: assert property (
    st_q == ST_ADDR |-> !muxed_addr_data_oe_b &&
      muxed_addr_data_out == {addr_q, size_q})
    else $error("address state does not drive address and size");
  a_burst_length: assert property (
    adv && word_ok && last |-> seen_q == {1'b0, size_q})
    else $error("burst ended at wrong word count");
  a_bus_floats: assert property (
    st_q inside {ST_IDLE, ST_LOCKW, ST_HOLD} |-> muxed_addr_data_oe_b)
    else $error("bus driven outside address or write data");
  a_latch_in_addr: assert property (
    st_q == ST_ADDR && adv |=> addr_latch_strobe_n)
    else $error("latch strobe still low in data state");
  a_latch_hold: assert property (
    st_q == ST_HOLD |-> addr_latch_strobe_oe_b)
    else $error("latch strobe driven during hold");
  a_strobe_first: assert property (
    st_q == ST_ADDR && adv |-> !addr_data_strobe_n ##1 addr_data_strobe_n)
    else $error("status strobe wrong around address state");
  a_strobe_burst: assert property (
    adv && word_ok && !last |=> !addr_data_strobe_n [*2])
    else $error("no status strobe for next burst word");
  a_strobe_wait: assert property (
    adv && st_q == ST_DATA && !rdy |=> addr_data_strobe_n [*2])
    else $error("status strobe during wait state");
  a_wr_stable: assert property (
    st_q == ST_DATA && $past(st_q) == ST_DATA |-> $stable(write_not_read))
    else $error("write/read moved inside data states");
  a_dir_data: assert property (
    st_q == ST_DATA |-> xcvr_direction == wr_q)
    else $error("direction wrong for transfer type");
  a_dir_quiet: assert property (
    $changed(xcvr_direction) |-> $past(xcvr_enable_oe_b))
    else $error("direction changed with transceivers on");
  a_en_data: assert property (
    st_q == ST_DATA |-> !xcvr_enable_oe_b)
    else $error("transceiver enable off in data state");
  a_lock_wait: assert property (
    st_q == ST_LOCKW && !lock_free |=> st_q == ST_LOCKW)
    else $error("atomic left lock wait while line busy");
  a_lock_pair: assert property (
    st_q == ST_ADDR && rmw_q |-> bus_lock_oe_b == wr_q)
    else $error("lock wrong in atomic address state");
  a_end_idle: assert property (
    adv && word_ok && last && !rmw_turn |=> st_q inside {ST_IDLE, ST_ADDR})
    else $error("no idle or address after last word");

  c_burst: cover property (adv && word_ok && !last ##[1:20] xfer_done);
  c_wait: cover property (adv && st_q == ST_DATA && !rdy);
  c_atomic: cover property (st_q == ST_ADDR && rmw_q && wr_q);
  c_hold: cover property (st_q == ST_HOLD);
endmodule

// ### lbm_agent.sv
// Purpose: far-side agent model for the local bus master
// Assumes: lock line pulled up; ready idles high
// Notes:   read words derive from the latched word address
`timescale 1ns/1ps
module lbm_agent
  import lbm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              ext_lock,
  input  wire logic [DATA_W-1:0] mad_out,
  input  wire logic              mad_oe_b,
  input  wire logic              latch_n,
  input  wire logic              dir,
  input  wire logic              en_n,
  input  wire logic              en_oe_b,
  input  wire logic              lock_n_out,
  input  wire logic              lock_oe_b,
  output logic [DATA_W-1:0]      mad_wire,
  output logic                   ready_n,
  output logic                   lock_wire_n
);
  logic [WADDR_W-1:0] addr_q;
  logic [DATA_W-1:0]  last_q;
  logic               en_q;
  logic               en;
  assign en = (en_oe_b == OE_ON) && (en_n == ACT_N);
  assign lock_wire_n = !((lock_oe_b == OE_ON && lock_n_out == ACT_N)
                         || ext_lock);
  // a released bus shows a changing pattern, never its last word
  assign mad_wire = (mad_oe_b == OE_ON) ? mad_out :
    (en && dir == DIR_RX) ? {addr_q, 2'h0} ^ 32'hc3c3_0000 : ~last_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= '0;
      last_q <= '0;
      en_q <= 1'b0;
      ready_n <= 1'b1;
    end else begin
      last_q <= mad_wire;
      en_q <= en;
      if (latch_n == ACT_N && mad_oe_b == OE_ON)
        addr_q <= mad_out[DATA_W-1:ADDR_LSB];
      // ready only after a full enabled cycle, with random stalls
      ready_n <= #1 !(en && en_q && ($urandom_range(3) != 0));
    end
  end
endmodule

// ### local_bus_master_interface_tb.sv
// Purpose: self-checking bench for the local bus master
// Assumes: agent answers reads with address-derived words
// Notes:   expected bus words and read data are queued ahead
`timescale 1ns/1ps
module local_bus_master_interface_tb;
  import lbm_pkg::*;
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
  logic              clk_sys = 1'b0;
  logic              rst_b = 1'b0;
  logic              hold_req_in = 1'b0;
  logic              ext_lock = 1'b0;
  logic              latch_prev = 1'b1;
  logic              clk_en = 1'b1;
  logic              stall_on = 1'b0;
  lbm_req_t          core_req = '0;
  logic [DATA_W-1:0] wdata = 32'h0;
  lbm_rdata_t        rdata;
  logic [DATA_W-1:0] mad_out, mad_wire;
  logic req_ready, wdata_take, xfer_done, hold_grant, mad_oe_b, latch_n;
  logic latch_oe_b, ads_n, wnr, dir, en_n, en_oe_b, ready_n, lock_n;
  logic lock_n_out, lock_oe_b;
  logic [33:0]       cur;
  logic [33:0]       exp_addr[$];
  logic [DATA_W-1:0] exp_rd[$];
  logic [DATA_W-1:0] exp_w;
  int errors = 0, n_checks = 0, n_xfer = 0, n_done = 0;
  int n_words = 0, n_ads = 0, exp_take = 0, n_take = 0;

  always #5 clk_sys = ~clk_sys;

  lbm_master uut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .core_req(core_req), .req_ready(req_ready), .wdata(wdata),
    .wdata_take(wdata_take), .rdata(rdata), .xfer_done(xfer_done),
    .hold_req_in(hold_req_in), .hold_grant(hold_grant),
    .muxed_addr_data_in(mad_wire), .muxed_addr_data_out(mad_out),
    .muxed_addr_data_oe_b(mad_oe_b), .addr_latch_strobe_n(latch_n),
    .addr_latch_strobe_oe_b(latch_oe_b), .addr_data_strobe_n(ads_n),
    .write_not_read(wnr), .xcvr_direction(dir), .xcvr_enable_n(en_n),
    .xcvr_enable_oe_b(en_oe_b), .ready_n_in(ready_n),
    .bus_lock_n_in(lock_n), .bus_lock_n_out(lock_n_out),
    .bus_lock_oe_b(lock_oe_b));
  lbm_agent agent (.clk_sys(clk_sys), .rst_b(rst_b), .ext_lock(ext_lock),
    .mad_out(mad_out), .mad_oe_b(mad_oe_b), .latch_n(latch_n), .dir(dir),
    .en_n(en_n), .en_oe_b(en_oe_b), .lock_n_out(lock_n_out),
    .lock_oe_b(lock_oe_b), .mad_wire(mad_wire), .ready_n(ready_n),
    .lock_wire_n(lock_n));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic stuck(input string what);
    errors++;
    $display("MISMATCH %s exp 1 got 0", what);
    give_verdict();
  endtask

  // keep leaves valid up so the next call follows back to back
  task automatic xfer(input logic [1:0] sz, input logic wr, atomic_read_then_write, inta,
                      keep);
    logic [WADDR_W-1:0] a;
    int k;
    a = WADDR_W'($urandom);
    exp_addr.push_back({atomic_read_then_write | inta, wr, a, sz});
    if (atomic_read_then_write) exp_addr.push_back({2'b01, a, sz});
    for (k = 0; k <= sz; k++) begin
      if (!wr) exp_rd.push_back({a, 2'h0} ^ 32'hc3c3_0000);
    end
    n_words += (atomic_read_then_write ? 2 : 1) * (sz + 1);
    if (wr || atomic_read_then_write) exp_take += sz + 1;
    n_xfer++;
    core_req = '{valid: 1'b1, addr: a, size: sz, wr: wr, atomic_read_then_write: atomic_read_then_write,
                 inta: inta};
    for (k = 0; k < 500; k++) begin
      @(negedge clk_sys);
      if (req_ready === 1'b1) break;
    end
    if (k == 500) stuck("req_ready");
    @(posedge clk_sys);
    #1;
    if (!keep) core_req.valid = 1'b0;
  endtask

  // outputs are read on the edge, before that edge's updates land
  // stalls only in the random test; frozen edges are not counted
  always @(posedge clk_sys) begin
    clk_en <= #1 !stall_on || ($urandom_range(3) != 0);
  end

  always @(posedge clk_sys) begin
    latch_prev <= latch_n;
    if (wdata_take === 1'b1) begin
      n_take++;
      `CHK("write_data", wdata, mad_out)
      `CHK("write_drive", OE_ON, mad_oe_b)
      wdata <= #1 $urandom;
    end
    if (rst_b) begin
      if (ads_n === ACT_N && clk_en === 1'b1) n_ads++;
      if (xfer_done === 1'b1 && clk_en === 1'b1) n_done++;
      if (latch_n === ACT_N && latch_oe_b === OE_ON &&
          latch_prev !== ACT_N) begin
        cur = exp_addr.pop_front();
        `CHK("addr_size", cur[31:0], mad_out)
        `CHK("lock_wait", 1'b0, cur[33] & ext_lock)
      end
      if (en_oe_b === OE_ON) begin
        `CHK("write_not_read", cur[32], wnr)
        `CHK("direction", cur[32], dir)
        `CHK("lock_held", ~cur[33], lock_oe_b)
        `CHK("enable_level", ACT_N, en_n)
      end
      if (hold_grant === 1'b1) begin
        `CHK("latch_float", OE_OFF, latch_oe_b)
        `CHK("bus_float", OE_OFF, mad_oe_b)
      end
      if (rdata.valid === 1'b1 && clk_en === 1'b1) begin
        exp_w = exp_rd.pop_front();
        `CHK("read_data", exp_w, rdata.data)
      end
      if (lock_oe_b === OE_ON) begin
        `CHK("lock_pull", ACT_N, lock_n_out)
      end
    end
  end

  initial begin
    int i;
    int r;
    r = $urandom(32'he650);
    repeat (20) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    @(posedge clk_sys);
    #1;
    for (i = 0; i < 8; i++) xfer(i[1:0], i[2], 1'b0, 1'b0, i < 7);
    $display("test sizes done");
    for (i = 0; i < 4; i++) xfer(i[1:0], 1'b0, 1'b1, 1'b0, 1'b1);
    xfer(2'h3, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("test atomic done");
    hold_req_in = 1'b1;
    for (i = 0; i < 300 && hold_grant !== 1'b1; i++) @(posedge clk_sys);
    if (i == 300) stuck("hold_grant");
    repeat (8) @(posedge clk_sys);
    #1 hold_req_in = 1'b0;
    $display("test hold done");
    @(posedge clk_sys);
    #1 ext_lock = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    xfer(2'h1, 1'b0, 1'b1, 1'b0, 1'b0);
    repeat (30) @(posedge clk_sys);
    #1 ext_lock = 1'b0;
    stall_on = 1'b1;
    $display("test lock done");
    for (i = 0; i < 24; i++) begin
      r = $urandom_range(3);
      xfer(2'($urandom), r == 1, r == 2, r == 3, i < 23);
    end
    for (i = 0; i < 1000 && n_done != n_xfer; i++) @(posedge clk_sys);
    `CHK("done_count", n_xfer, n_done)
    `CHK("reads_left", 0, exp_rd.size())
    `CHK("strobe_cycles", 2 * n_words, n_ads)
    `CHK("write_takes", exp_take, n_take)
    $display("test random done");
    give_verdict();
  end
endmodule
